//--- jtdp_consts.svh
// Constants of the test access port
`ifndef JTDP_CONSTS_SVH
`define JTDP_CONSTS_SVH
`define JTDP_IR_W 4
`define JTDP_IR_CAPTURE 4'h1
`define JTDP_IR_RESET 4'hE
`define JTDP_ID_W 32
`define JTDP_BSC_W 8
`define JTDP_PROG_W 16
`define JTDP_ISC_W 16
`define JTDP_BPC_W 16
`define JTDP_INS_EXTEST 4'h0
`define JTDP_INS_IDCODE 4'h1
`define JTDP_INS_SAMPLE 4'h2
`define JTDP_INS_PROG 4'h4
`define JTDP_INS_ISCAN 4'h8
`define JTDP_INS_BPSCAN 4'h9
`define JTDP_INS_BYPASS 4'hF
`define JTDP_SEL_IR 3'h0
`define JTDP_SEL_BYP 3'h1
`define JTDP_SEL_ID 3'h2
`define JTDP_SEL_BSC 3'h3
`define JTDP_SEL_PROG 3'h4
`define JTDP_SEL_ISC 3'h5
`define JTDP_SEL_BPC 3'h6
`endif

//--- jtdp_pkg.sv
// Types of the test access port
package jtdp_pkg;
  typedef enum logic [3:0] {
    JTDP_TLR, JTDP_RTI, JTDP_SEL_DR, JTDP_CAP_DR, JTDP_SH_DR, JTDP_EX1_DR,
    JTDP_PA_DR, JTDP_EX2_DR, JTDP_UPD_DR, JTDP_SEL_IR, JTDP_CAP_IR,
    JTDP_SH_IR, JTDP_EX1_IR, JTDP_PA_IR, JTDP_EX2_IR, JTDP_UPD_IR
  } jtdp_state_t;
endpackage : jtdp_pkg

//--- jtdp_sync.sv
// Two-stage synchroniser, both stages loaded high while in reset
`timescale 1ns/100ps
module jtdp_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pin in, synchronised out
  input wire logic pin,
  output logic level
);
  logic stage1;
  logic next_stage1;
  logic next_level;

  always_comb
  begin
    next_stage1 = rstn ? pin : 1'b1;
    next_level = rstn ? stage1 : 1'b1;
  end

  always_ff @(posedge clk)
  begin
    stage1 <= next_stage1;
    level <= next_level;
  end
endmodule : jtdp_sync

//--- jtdp_tap.sv
// Test access port: TAP state machine, instruction and data registers
//
// What this block does
// - Sixteen-state machine steered only by mode select
// - IR or one data register forms shift path
// - Instruction picks data register and its behaviour
// - Identification, bypass and boundary-scan registers present
// - Programming, internal scan, breakpoint chains present
// - State and registers advance on test clock rising edges; data out and its enable on falling
// - Tester drives data in; device shifts it
// - Selected register's bits appear on data out
// - No dedicated test reset input exists
// - Fuse unprogrammed: pins released, machine held reset
// - Fuse set, disable clear: active, pulled high
// - Data out floats unless shifting
// - Sixteen states, reset to test-logic-reset
// - Least significant bit shifts first
// - Five mode-select highs reach test-logic-reset
// - Four-bit IR captures 0x01 in capture-IR
`timescale 1ns/100ps
`include "jtdp_consts.svh"
module jtdp_tap
  import jtdp_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary value
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Port enables
  input wire logic test_port_enable_fuse,
  input wire logic test_port_disable_bit,
  // Test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  output logic pins_active,
  output logic pullup_en,
  // Boundary and debug parallel side
  input wire logic [7:0] bsc_pins_in,
  output logic [7:0] bsc_pins_out,
  output logic bsc_drive,
  output logic [15:0] prog_word,
  output logic prog_strobe,
  output logic [15:0] iscan_word,
  output logic [15:0] bpscan_word,
  // System reset line, open drain
  input wire logic sys_reset_n_in,
  output logic sys_reset_seen,
  output logic sys_reset_n_out,
  output logic sys_reset_oe,
  input wire logic dbg_reset_req,
  // State for observation
  output logic [`JTDP_IR_W-1:0] instr
);
  // ****************************************************
  // Pin sampling
  // ****************************************************
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic rst_s;
  logic tck_d;
  logic rise;
  logic fall;
  logic enabled;
  logic [7:0] bsc_s1;
  logic [7:0] bsc_s2;
  logic [7:0] next_bsc_s1;
  logic [7:0] next_bsc_s2;

  jtdp_sync u_tck (.clk(clk), .rstn(rstn), .pin(tck), .level(tck_s));
  jtdp_sync u_tms (.clk(clk), .rstn(rstn), .pin(tms), .level(tms_s));
  jtdp_sync u_tdi (.clk(clk), .rstn(rstn), .pin(tdi), .level(tdi_s));
  jtdp_sync u_rst (.clk(clk), .rstn(rstn), .pin(sys_reset_n_in),
    .level(rst_s));

  assign enabled = test_port_enable_fuse & ~test_port_disable_bit;
  assign rise = tck_s & ~tck_d;
  assign fall = ~tck_s & tck_d;

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [2:0] sel_of(input logic [3:0] ins);
    unique case (ins)
      `JTDP_INS_IDCODE: sel_of = `JTDP_SEL_ID;
      `JTDP_INS_EXTEST, `JTDP_INS_SAMPLE: sel_of = `JTDP_SEL_BSC;
      `JTDP_INS_PROG: sel_of = `JTDP_SEL_PROG;
      `JTDP_INS_ISCAN: sel_of = `JTDP_SEL_ISC;
      `JTDP_INS_BPSCAN: sel_of = `JTDP_SEL_BPC;
      default: sel_of = `JTDP_SEL_BYP;
    endcase
  endfunction : sel_of

  function automatic jtdp_state_t step(input jtdp_state_t s,
    input logic m);
    unique case (s)
      JTDP_TLR: step = m ? JTDP_TLR : JTDP_RTI;
      JTDP_RTI: step = m ? JTDP_SEL_DR : JTDP_RTI;
      JTDP_SEL_DR: step = m ? JTDP_SEL_IR : JTDP_CAP_DR;
      JTDP_CAP_DR: step = m ? JTDP_EX1_DR : JTDP_SH_DR;
      JTDP_SH_DR: step = m ? JTDP_EX1_DR : JTDP_SH_DR;
      JTDP_EX1_DR: step = m ? JTDP_UPD_DR : JTDP_PA_DR;
      JTDP_PA_DR: step = m ? JTDP_EX2_DR : JTDP_PA_DR;
      JTDP_EX2_DR: step = m ? JTDP_UPD_DR : JTDP_SH_DR;
      JTDP_UPD_DR: step = m ? JTDP_SEL_DR : JTDP_RTI;
      JTDP_SEL_IR: step = m ? JTDP_TLR : JTDP_CAP_IR;
      JTDP_CAP_IR: step = m ? JTDP_EX1_IR : JTDP_SH_IR;
      JTDP_SH_IR: step = m ? JTDP_EX1_IR : JTDP_SH_IR;
      JTDP_EX1_IR: step = m ? JTDP_UPD_IR : JTDP_PA_IR;
      JTDP_PA_IR: step = m ? JTDP_EX2_IR : JTDP_PA_IR;
      JTDP_EX2_IR: step = m ? JTDP_UPD_IR : JTDP_SH_IR;
      JTDP_UPD_IR: step = m ? JTDP_SEL_DR : JTDP_RTI;
    endcase
  endfunction : step

  // ****************************************************
  // TAP state and registers
  // ****************************************************
  jtdp_state_t state;
  jtdp_state_t next_state;
  logic [3:0] ir_sh;
  logic [3:0] next_ir_sh;
  logic [3:0] next_instr;
  logic byp;
  logic next_byp;
  logic [31:0] id_sh;
  logic [31:0] next_id_sh;
  logic [7:0] bsc_sh;
  logic [7:0] next_bsc_sh;
  logic [7:0] next_bsc_pins_out;
  logic [15:0] prog_sh;
  logic [15:0] next_prog_sh;
  logic [15:0] next_prog_word;
  logic next_prog_strobe;
  logic [15:0] isc_sh;
  logic [15:0] next_isc_sh;
  logic [15:0] next_iscan_word;
  logic [15:0] bpc_sh;
  logic [15:0] next_bpc_sh;
  logic [15:0] next_bpscan_word;
  logic next_tdo;
  logic next_tdo_oe;
  logic shifting;
  logic [2:0] sel;

  assign sel = sel_of(instr);
  // Decoded from the state alone, high in Shift-DR or Shift-IR; no separate test reset pin
  assign shifting = (state == JTDP_SH_DR) || (state == JTDP_SH_IR);

  always_comb
  begin
    next_state = state;
    next_ir_sh = ir_sh;
    next_instr = instr;
    next_byp = byp;
    next_id_sh = id_sh;
    next_bsc_sh = bsc_sh;
    next_bsc_pins_out = bsc_pins_out;
    next_prog_sh = prog_sh;
    next_prog_word = prog_word;
    next_prog_strobe = 1'b0;
    next_isc_sh = isc_sh;
    next_iscan_word = iscan_word;
    next_bpc_sh = bpc_sh;
    next_bpscan_word = bpscan_word;
    next_tdo = tdo;
    next_tdo_oe = tdo_oe;
    if (!enabled)
    begin
      next_state = JTDP_TLR;
      next_instr = `JTDP_IR_RESET;
      next_tdo_oe = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        next_state = step(state, tms_s);
        unique case (state)
          JTDP_TLR: next_instr = `JTDP_IR_RESET;
          JTDP_CAP_IR: next_ir_sh = `JTDP_IR_CAPTURE;
          JTDP_SH_IR: next_ir_sh = {tdi_s, ir_sh[3:1]};
          JTDP_UPD_IR: next_instr = ir_sh;
          JTDP_CAP_DR:
          begin
            next_byp = 1'b0;
            next_id_sh = ID_VALUE;
            next_bsc_sh = bsc_s2;
            next_prog_sh = prog_word;
            next_isc_sh = iscan_word;
            next_bpc_sh = bpscan_word;
          end
          JTDP_SH_DR:
          begin
            unique case (sel)
              `JTDP_SEL_ID: next_id_sh = {tdi_s, id_sh[31:1]};
              `JTDP_SEL_BSC: next_bsc_sh = {tdi_s, bsc_sh[7:1]};
              `JTDP_SEL_PROG: next_prog_sh = {tdi_s, prog_sh[15:1]};
              `JTDP_SEL_ISC: next_isc_sh = {tdi_s, isc_sh[15:1]};
              `JTDP_SEL_BPC: next_bpc_sh = {tdi_s, bpc_sh[15:1]};
              default: next_byp = tdi_s;
            endcase
          end
          JTDP_UPD_DR:
          begin
            unique case (sel)
              `JTDP_SEL_BSC: next_bsc_pins_out = bsc_sh;
              `JTDP_SEL_PROG:
              begin
                next_prog_word = prog_sh;
                next_prog_strobe = 1'b1;
              end
              `JTDP_SEL_ISC: next_iscan_word = isc_sh;
              `JTDP_SEL_BPC: next_bpscan_word = bpc_sh;
              default: next_instr = instr;
            endcase
          end
          default: next_state = step(state, tms_s);
        endcase
        if (next_state == JTDP_TLR)
          next_instr = `JTDP_IR_RESET;
      end
      // Output changes on the falling edge so tester samples stable data
      if (fall)
      begin
        next_tdo_oe = shifting;
        if (state == JTDP_SH_IR)
          next_tdo = ir_sh[0];
        else
        begin
          unique case (sel)
            `JTDP_SEL_ID: next_tdo = id_sh[0];
            `JTDP_SEL_BSC: next_tdo = bsc_sh[0];
            `JTDP_SEL_PROG: next_tdo = prog_sh[0];
            `JTDP_SEL_ISC: next_tdo = isc_sh[0];
            `JTDP_SEL_BPC: next_tdo = bpc_sh[0];
            default: next_tdo = byp;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= JTDP_TLR;
      ir_sh <= `JTDP_IR_CAPTURE;
      instr <= `JTDP_IR_RESET;
      byp <= 1'b0;
      id_sh <= 32'h0000_0000;
      bsc_sh <= 8'h00;
      bsc_pins_out <= 8'h00;
      prog_sh <= 16'h0000;
      prog_word <= 16'h0000;
      prog_strobe <= 1'b0;
      isc_sh <= 16'h0000;
      iscan_word <= 16'h0000;
      bpc_sh <= 16'h0000;
      bpscan_word <= 16'h0000;
      tdo <= 1'b1;
      tdo_oe <= 1'b0;
      tck_d <= 1'b1;
    end
    else
    begin
      state <= next_state;
      ir_sh <= next_ir_sh;
      instr <= next_instr;
      byp <= next_byp;
      id_sh <= next_id_sh;
      bsc_sh <= next_bsc_sh;
      bsc_pins_out <= next_bsc_pins_out;
      prog_sh <= next_prog_sh;
      prog_word <= next_prog_word;
      prog_strobe <= next_prog_strobe;
      isc_sh <= next_isc_sh;
      iscan_word <= next_iscan_word;
      bpc_sh <= next_bpc_sh;
      bpscan_word <= next_bpscan_word;
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
      tck_d <= tck_s;
    end
  end

  // ****************************************************
  // Port ownership, boundary drive and system reset line
  // ****************************************************
  logic next_pins_active;
  logic next_bsc_drive;
  logic next_seen;
  logic next_rst_oe;

  always_comb
  begin
    next_pins_active = enabled;
    next_bsc_drive = enabled && (instr == `JTDP_INS_EXTEST);
    next_seen = enabled && !rst_s;
    next_rst_oe = enabled && dbg_reset_req;
    next_bsc_s1 = bsc_pins_in;
    next_bsc_s2 = bsc_s1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pins_active <= 1'b0;
      pullup_en <= 1'b0;
      bsc_drive <= 1'b0;
      sys_reset_seen <= 1'b0;
      sys_reset_n_out <= 1'b0;
      sys_reset_oe <= 1'b0;
      bsc_s1 <= 8'h00;
      bsc_s2 <= 8'h00;
    end
    else
    begin
      pins_active <= next_pins_active;
      pullup_en <= next_pins_active;
      bsc_drive <= next_bsc_drive;
      sys_reset_seen <= next_seen;
      sys_reset_n_out <= 1'b0;
      sys_reset_oe <= next_rst_oe;
      bsc_s1 <= next_bsc_s1;
      bsc_s2 <= next_bsc_s2;
    end
  end
endmodule : jtdp_tap

//--- jtdp_chk_assertions.sv
// Assertion checker for the test access port
`timescale 1ns/100ps
`include "jtdp_consts.svh"
module jtdp_chk
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Enables and pins
  input wire logic test_port_enable_fuse,
  input wire logic test_port_disable_bit,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic pins_active,
  input wire logic pullup_en,
  // Side outputs
  input wire logic bsc_drive,
  input wire logic prog_strobe,
  input wire logic sys_reset_n_out,
  input wire logic sys_reset_oe,
  input wire logic sys_reset_seen,
  input wire logic [`JTDP_IR_W-1:0] instr
);
  // ********
  // Properties
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_off;
    (!test_port_enable_fuse || test_port_disable_bit) [*2];
  endsequence
  sequence s_on;
    (test_port_enable_fuse && !test_port_disable_bit) [*2];
  endsequence
  // Both outputs registered, so one cycle of lag on pins_active is allowed
  sequence s_live;
    pins_active && $past(pins_active);
  endsequence
  off_pins_a: assert property (s_off |->
    !pins_active && !tdo_oe)
    else $error("port active while off");
  off_instr_a: assert property (s_off |->
    instr == `JTDP_IR_RESET)
    else $error("instruction not reset while off");
  off_reset_a: assert property (s_off |->
    !sys_reset_oe && !sys_reset_seen)
    else $error("reset line used while off");
  on_pins_a: assert property (s_on |->
    pins_active && pullup_en)
    else $error("port not active while on");
  tdo_fall_a: assert property (($changed(tdo) and s_live) |->
    !$past(tck, 2))
    else $error("data out moved without test clock fall");
  oe_fall_a: assert property (($changed(tdo_oe) and s_live) |->
    !$past(tck, 2))
    else $error("output enable moved without test clock fall");
  extest_only_a: assert property ($stable(instr) &&
    instr != `JTDP_INS_EXTEST |-> !bsc_drive)
    else $error("boundary drive outside extest");
  strobe_pulse_a: assert property (prog_strobe |=> !prog_strobe)
    else $error("program strobe longer than one cycle");
  open_drain_a: assert property (!sys_reset_n_out)
    else $error("reset line driven high");
endmodule : jtdp_chk

//--- jtdp_tester.sv
// Model of the external tester that drives the test pins
`timescale 1ns/100ps
module jtdp_tester
(
  // Test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_line
);
  // ********
  // Test clock periods of 160 ns, clock low between frames
  // ********
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // Data out is read at the end of the low phase, where it has settled
  task automatic step(input logic m, input logic b, output logic o);
    tms = m;
    tdi = b;
    #80;
    o = tdo_line;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask : step
  task automatic go(input logic [7:0] seq, input int n);
    logic o;
    for (int i = 0; i < n; i++)
    begin
      step(seq[i], 1'b1, o);
    end
  endtask : go
  task automatic shift(input int n, input logic [31:0] din,
    output logic [31:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], dout[i]);
    end
    go(8'h01, 2);
  endtask : shift
  task automatic ir(input logic [3:0] v, output logic [3:0] o);
    logic [31:0] q;
    go(8'h03, 4);
    shift(4, {28'h0, v}, q);
    o = q[3:0];
  endtask : ir
  task automatic dr(input int n, input logic [31:0] din,
    output logic [31:0] dout);
    go(8'h01, 3);
    shift(n, din, dout);
  endtask : dr
endmodule : jtdp_tester

//--- tb_top.sv
// Self-checking bench for the test access port
`timescale 1ns/100ps
`include "jtdp_consts.svh"
module tb_top;
  localparam logic [31:0] ID = 32'h5A3C_96E1; // Arbitrary value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic fuse = 1'b1;
  logic dis = 1'b0;
  logic pull_rst = 1'b0;
  logic req = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, pins_active, bsc_drive;
  logic sys_reset_seen, sys_reset_oe, pullup_en, prog_strobe;
  logic [7:0] bsc_pins_out;
  logic [15:0] prog_word, iscan_word, bpscan_word;
  logic [3:0] instr, o4;
  logic [31:0] d;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int n_strobe = 0;
  // ********
  // Board wiring and instances
  // ********
  wire tdo_line = tdo_oe ? tdo : 1'b1;
  wire sys_line = !(sys_reset_oe || pull_rst);
  jtdp_tap #(.ID_VALUE(ID)) i_dut
  (
    .clk, .rstn, .test_port_enable_fuse(fuse), .test_port_disable_bit(dis),
    .tck, .tms, .tdi, .tdo, .tdo_oe, .pins_active, .pullup_en,
    .bsc_pins_in(8'h3C), .bsc_pins_out, .bsc_drive, .prog_word,
    .prog_strobe, .iscan_word, .bpscan_word, .sys_reset_n_in(sys_line),
    .sys_reset_seen, .sys_reset_n_out(), .sys_reset_oe,
    .dbg_reset_req(req), .instr
  );
  jtdp_tester i_tst (.tck, .tms, .tdi, .tdo_line);
  always #5 clk = ~clk;
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (prog_strobe === 1'b1)
      n_strobe <= n_strobe + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_id;
    i_tst.go(8'h1F, 6);
    chk(instr, `JTDP_IR_RESET);
    i_tst.ir(`JTDP_INS_IDCODE, o4);
    chk(o4, `JTDP_IR_CAPTURE);
    chk(instr, `JTDP_INS_IDCODE);
    i_tst.dr(32, 32'h0, d);
    chk(d, ID);
  endtask : t_id
  task automatic t_off;
    settle(1);
    dis = 1'b1;
    settle(4);
    i_tst.ir(`JTDP_INS_IDCODE, o4);
    chk(pins_active, 1'b0);
    chk(pullup_en, 1'b0);
    chk(instr, `JTDP_IR_RESET);
    fuse = 1'b0;
    dis = 1'b0;
    settle(4);
    chk(pins_active, 1'b0);
    fuse = 1'b1;
    settle(4);
    chk(pins_active, 1'b1);
    chk(pullup_en, 1'b1);
    i_tst.go(8'h00, 1);
  endtask : t_off
  task automatic t_bypass;
    i_tst.ir(`JTDP_INS_BYPASS, o4);
    i_tst.dr(8, 32'hA5, d);
    chk(d, 32'h4A);
    chk(tdo_line, 1'b1);
    chk(tdo_oe, 1'b0);
    i_tst.ir(4'h3, o4);
    i_tst.dr(2, 32'h3, d);
    chk(d, 32'h2);
  endtask : t_bypass
  task automatic t_chains;
    i_tst.ir(`JTDP_INS_SAMPLE, o4);
    i_tst.dr(8, 32'hC3, d);
    chk(d, 32'h3C);
    i_tst.ir(`JTDP_INS_EXTEST, o4);
    i_tst.dr(8, 32'h5A, d);
    chk(bsc_pins_out, 8'h5A);
    chk(bsc_drive, 1'b1);
    i_tst.ir(`JTDP_INS_PROG, o4);
    i_tst.dr(16, 32'hBEEF, d);
    chk(prog_word, 16'hBEEF);
    chk(n_strobe, 32'h1);
    i_tst.ir(`JTDP_INS_ISCAN, o4);
    i_tst.dr(16, 32'h1357, d);
    chk(iscan_word, 16'h1357);
    i_tst.ir(`JTDP_INS_BPSCAN, o4);
    i_tst.dr(16, 32'h2468, d);
    chk(bpscan_word, 16'h2468);
    chk(bsc_drive, 1'b0);
  endtask : t_chains
  task automatic t_tlr;
    i_tst.go(8'h01, 3);
    i_tst.go(8'h1F, 5);
    chk(instr, `JTDP_IR_RESET);
    chk(tdo_line, 1'b1);
    i_tst.go(8'h00, 1);
  endtask : t_tlr
  task automatic t_rst;
    settle(1);
    pull_rst = 1'b1;
    settle(8);
    chk(sys_reset_seen, 1'b1);
    pull_rst = 1'b0;
    req = 1'b1;
    settle(8);
    chk(sys_line, 1'b0);
    req = 1'b0;
    settle(8);
    chk(sys_line, 1'b1);
  endtask : t_rst
  initial
  begin
    settle(8);
    rstn = 1'b1;
    settle(4);
    t_id();
    t_off();
    t_bypass();
    t_chains();
    t_tlr();
    t_rst();
    report_and_stop();
  end
endmodule : tb_top
bind jtdp_tap jtdp_chk i_chk (.clk, .rstn, .test_port_enable_fuse,
  .test_port_disable_bit, .tck, .tdo, .tdo_oe, .pins_active, .pullup_en,
  .bsc_drive, .prog_strobe, .sys_reset_n_out, .sys_reset_oe,
  .sys_reset_seen, .instr);
